// ---- hcg_regs.svh ----
// Constants of the hop channel generator: sequence lengths, wrap thresholds, ranges and reset values.
`ifndef HCG_REGS_SVH
`define HCG_REGS_SVH

// Australia: 60 channels, wrap above 61, sequence selector 1 to 20.
`define HCG_AU_LEN      7'h3C
`define HCG_AU_THR      8'h3D
`define HCG_AU_SEQ_MAX  5'h14

// Canada and Mexico: 30 channels, wrap above 81, sequence selector 1 to 10.
`define HCG_CM_LEN      7'h1E
`define HCG_CM_THR      8'h51
`define HCG_CM_SEQ_MAX  5'h0A
`define HCG_CM_CH1      7'h34
`define HCG_CM_CH2      7'h3A
`define HCG_CM_FILL     7'h34

// Europe, US and International: 79 channels, wrap above 80, sequence selector 1 to 26.
`define HCG_EU_LEN      7'h4F
`define HCG_EU_THR      8'h50
`define HCG_EU_SEQ_MAX  5'h1A

// France: 35 channels, wrap above 82, sequence selector 1 to 11.
`define HCG_FR_LEN      7'h23
`define HCG_FR_THR      8'h52
`define HCG_FR_SEQ_MAX  5'h0B

// Shared figures: set step, set range, first index and frequency base in MHz.
`define HCG_SET_STEP    8'h03
`define HCG_SET_MIN     2'h1
`define HCG_SET_MAX     2'h3
`define HCG_IDX_FIRST   7'h01
`define HCG_FREQ_BASE   12'h960

`endif

// ---- hcg_pkg.sv ----
// Types shared by the hop channel generator.
package hcg_pkg;

    // Regional hopping standard selected on the region input.
    typedef enum logic [1:0] {
        HCG_AU = 2'h0,
        HCG_CM = 2'h1,
        HCG_EU = 2'h2,
        HCG_FR = 2'h3
    } hcg_region_e;

endpackage : hcg_pkg

// ---- hcg_top.sv ----
// Hop channel generator: basic tables, set and sequence offset, regional wrap and frequency.
`timescale 1ns/1ps
`include "hcg_regs.svh"

// Behaviour
// - Channel is basic entry plus set/sequence offset.
// - Hopping set accepted only from 1 to 3.
// - Australia wraps sums above 61 down 60.
// - Australia: sequence 1-20, index 1-60.
// - Australia basic table, 60 entries from index 1.
// - Canada/Mexico wraps sums above 81 down 30.
// - Canada/Mexico: index 1-30, sequence 1-10, starts 52,58.
// - Europe/US wraps sums above 80 down 79.
// - Europe/US: sequence 1-26, index 1-79.
// - Europe/US basic table, 79 entries from index 1.
// - France wraps sums above 82 down 35.
// - France: sequence 1-11, index 1-35.
// - France basic table, 35 entries from index 1.
// - Frequency in MHz is 2400 plus channel.
module hcg_top (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic [1:0] region,
    input  wire logic [1:0] hop_set,
    input  wire logic [4:0] hop_seq,
    input  wire logic       hop_req,
    input  wire logic       cm_wr_en,
    input  wire logic [4:0] cm_wr_idx,
    input  wire logic [6:0] cm_wr_chan,
    output logic      [6:0] hop_index,
    output logic      [6:0] chan_num,
    output logic     [11:0] freq_mhz,
    output logic            cfg_ok
);

    // Basic tables, index 1 in the top byte; each entry is one byte holding a 7-bit channel.
    localparam logic [8*60-1:0] AU_TBL = {
        8'h02, 8'h35, 8'h13, 8'h3A, 8'h10, 8'h32, 8'h0D, 8'h22, 8'h17, 8'h0F, 8'h2E, 8'h25, 8'h30, 8'h37, 8'h14,
        8'h3C, 8'h34, 8'h09, 8'h31, 8'h3B, 8'h1D, 8'h05, 8'h1F, 8'h11, 8'h1E, 8'h16, 8'h08, 8'h2B, 8'h3D, 8'h29,
        8'h18, 8'h0E, 8'h2A, 8'h23, 8'h06, 8'h12, 8'h1C, 8'h33, 8'h39, 8'h03, 8'h27, 8'h2F, 8'h38, 8'h0C, 8'h20,
        8'h26, 8'h1B, 8'h0B, 8'h1A, 8'h28, 8'h21, 8'h19, 8'h36, 8'h24, 8'h15, 8'h0A, 8'h04, 8'h2C, 8'h07, 8'h2D
    };
    localparam logic [8*79-1:0] EU_TBL = {
        8'h02, 8'h19, 8'h40, 8'h0A, 8'h2D, 8'h12, 8'h49, 8'h31, 8'h15, 8'h3F, 8'h4E, 8'h1F, 8'h3D, 8'h18, 8'h36,
        8'h41, 8'h1C, 8'h4F, 8'h21, 8'h04, 8'h14, 8'h0D, 8'h26, 8'h4A, 8'h38, 8'h47, 8'h17, 8'h05, 8'h27, 8'h0C,
        8'h24, 8'h44, 8'h09, 8'h46, 8'h4D, 8'h06, 8'h3E, 8'h1D, 8'h0E, 8'h1B, 8'h10, 8'h3B, 8'h2B, 8'h4C, 8'h22,
        8'h48, 8'h0B, 8'h3C, 8'h50, 8'h2F, 8'h16, 8'h4B, 8'h42, 8'h29, 8'h0F, 8'h23, 8'h43, 8'h34, 8'h3A, 8'h04,
        8'h32, 8'h11, 8'h07, 8'h13, 8'h08, 8'h45, 8'h33, 8'h2A, 8'h03, 8'h1E, 8'h39, 8'h25, 8'h37, 8'h1A, 8'h2E,
        8'h35, 8'h28, 8'h20, 8'h30
    };
    localparam logic [8*35-1:0] FR_TBL = {
        8'h41, 8'h35, 8'h42, 8'h50, 8'h47, 8'h37, 8'h40, 8'h34, 8'h3D, 8'h51, 8'h4A, 8'h3A, 8'h4F, 8'h44, 8'h4D,
        8'h46, 8'h3C, 8'h36, 8'h4C, 8'h3E, 8'h49, 8'h30, 8'h38, 8'h31, 8'h3F, 8'h33, 8'h3B, 8'h4E, 8'h48, 8'h39,
        8'h4B, 8'h43, 8'h32, 8'h45, 8'h52
    };

    logic [6:0]  idx_reg;
    logic [6:0]  idx_next;
    logic [6:0]  chan_reg;
    logic [6:0]  chan_next;
    logic [11:0] freq_reg;
    logic [11:0] freq_next;
    logic        ok_reg;
    logic        ok_next;
    logic [6:0]  cm_reg  [0:29];
    logic [6:0]  cm_next [0:29];
    logic [6:0]  basic;
    logic [6:0]  len;
    logic [7:0]  thr;
    logic [4:0]  seq_max;
    logic [7:0]  set_off;
    logic [7:0]  seq_off;
    logic [7:0]  sum;

    // The Canada/Mexico table is only partly known, so it is a writable store; the first
    // two entries reset to 52 and 58, the rest reset to the fill value 52 until loaded.
    generate
        for (genvar k = 0; k < 30; k++) begin : g_cm
            always_comb begin
                cm_next[k] = cm_reg[k];
                if (cm_wr_en && cm_wr_idx == 5'(k + 1)) begin
                    cm_next[k] = cm_wr_chan;
                end
            end

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    cm_reg[k] <= (k == 0) ? `HCG_CM_CH1 : (k == 1) ? `HCG_CM_CH2 : `HCG_CM_FILL;
                end else if (clk_en) begin
                    cm_reg[k] <= cm_next[k];
                end
            end
        end
    endgenerate

    // Region lookup: sequence length, wrap threshold, selector range and basic entry at the index.
    // An index beyond the table, possible for one cycle after a region change, reads as zero.
    always_comb begin
        basic   = 7'h00;
        len     = `HCG_AU_LEN;
        thr     = `HCG_AU_THR;
        seq_max = `HCG_AU_SEQ_MAX;
        unique case (hcg_pkg::hcg_region_e'(region))
            hcg_pkg::HCG_AU: begin
                len     = `HCG_AU_LEN;
                thr     = `HCG_AU_THR;
                seq_max = `HCG_AU_SEQ_MAX;
                if (idx_reg >= `HCG_IDX_FIRST && idx_reg <= `HCG_AU_LEN) begin
                    basic = AU_TBL[8*(int'(`HCG_AU_LEN) - int'(idx_reg)) +: 7];
                end
            end
            hcg_pkg::HCG_CM: begin
                len     = `HCG_CM_LEN;
                thr     = `HCG_CM_THR;
                seq_max = `HCG_CM_SEQ_MAX;
                if (idx_reg >= `HCG_IDX_FIRST && idx_reg <= `HCG_CM_LEN) begin
                    basic = cm_reg[5'(idx_reg - `HCG_IDX_FIRST)];
                end
            end
            hcg_pkg::HCG_EU: begin
                len     = `HCG_EU_LEN;
                thr     = `HCG_EU_THR;
                seq_max = `HCG_EU_SEQ_MAX;
                if (idx_reg >= `HCG_IDX_FIRST && idx_reg <= `HCG_EU_LEN) begin
                    basic = EU_TBL[8*(int'(`HCG_EU_LEN) - int'(idx_reg)) +: 7];
                end
            end
            hcg_pkg::HCG_FR: begin
                len     = `HCG_FR_LEN;
                thr     = `HCG_FR_THR;
                seq_max = `HCG_FR_SEQ_MAX;
                if (idx_reg >= `HCG_IDX_FIRST && idx_reg <= `HCG_FR_LEN) begin
                    basic = FR_TBL[8*(int'(`HCG_FR_LEN) - int'(idx_reg)) +: 7];
                end
            end
        endcase
    end

    // Offset sum and regional wrap; the sum needs eight bits since it can reach 163 with sets 1 to 3.
    always_comb begin
        set_off   = ({6'h00, hop_set} - 8'h01) * `HCG_SET_STEP;
        seq_off   = {3'h0, hop_seq} - 8'h01;
        sum       = {1'b0, basic} + set_off + seq_off;
        chan_next = (sum > thr) ? 7'(sum - {1'b0, len}) : sum[6:0];
        freq_next = `HCG_FREQ_BASE + {5'h00, chan_next};
        ok_next   = (hop_set >= `HCG_SET_MIN) && (hop_set <= `HCG_SET_MAX)
                    && (hop_seq >= 5'h01) && (hop_seq <= seq_max);
    end

    // Index stepping; an index left beyond a shorter table by a region change falls back to 1.
    always_comb begin
        idx_next = idx_reg;
        if (hop_req) begin
            idx_next = (idx_reg >= len) ? `HCG_IDX_FIRST : idx_reg + 7'h01;
        end else if (idx_reg > len) begin
            idx_next = `HCG_IDX_FIRST;
        end
    end

    // Output registers; the channel follows the index one cycle later, so the freshly reset
    // index 1 is presented from the first enabled edge after release.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idx_reg  <= `HCG_IDX_FIRST;
            chan_reg <= 7'h00;
            freq_reg <= `HCG_FREQ_BASE;
            ok_reg   <= 1'b0;
        end else if (clk_en) begin
            idx_reg  <= idx_next;
            chan_reg <= chan_next;
            freq_reg <= freq_next;
            ok_reg   <= ok_next;
        end
    end

    assign hop_index = idx_reg;
    assign chan_num  = chan_reg;
    assign freq_mhz  = freq_reg;
    assign cfg_ok    = ok_reg;

    // Checks on the generator's own outputs.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_hop_at_end;
        clk_en && hop_req && idx_reg >= len;
    endsequence

    sequence s_hop_mid;
        clk_en && hop_req && idx_reg < len;
    endsequence

    a_index_wrap: assert property (s_hop_at_end |=> idx_reg == 7'h01)
        else $error("index did not return to 1 after last entry");
    a_index_step: assert property (s_hop_mid |=> idx_reg == $past(idx_reg) + 7'h01)
        else $error("index did not advance by one on hop");
    a_freq_chan: assert property (freq_reg == `HCG_FREQ_BASE + {5'h00, chan_reg})
        else $error("frequency is not 2400 plus channel");
    a_base_entry: assert property (clk_en && hop_set == 2'h1 && hop_seq == 5'h01 |=> chan_reg == $past(basic))
        else $error("basic set and sequence changed the channel");
    a_set_range: assert property (clk_en && hop_set == 2'h0 |=> !ok_reg)
        else $error("hopping set 0 accepted");
    a_au_wrap: assert property (clk_en && region == 2'h0 && ok_next && idx_reg <= 7'h3C
                                |=> chan_reg >= 7'h01 && chan_reg <= 7'h3D)
        else $error("Australian channel out of 1 to 61");
    a_cm_wrap: assert property (clk_en && region == 2'h1 && sum > 8'h51 |=> chan_reg == 7'($past(sum) - 8'h1E))
        else $error("Canada/Mexico wrap did not subtract 30");
    a_eu_wrap: assert property (clk_en && region == 2'h2 && sum > 8'h50 |=> chan_reg == 7'($past(sum) - 8'h4F))
        else $error("Europe/US wrap did not subtract 79");
    a_fr_wrap: assert property (clk_en && region == 2'h3 && sum > 8'h52 |=> chan_reg == 7'($past(sum) - 8'h23))
        else $error("French wrap did not subtract 35");
    a_freeze_hold: assert property (!clk_en |=> $stable(idx_reg) && $stable(chan_reg))
        else $error("state moved while clock enable low");
    a_seq_range: assert property (clk_en && region == 2'h3 && hop_seq == 5'h0C |=> !ok_reg)
        else $error("French sequence 12 accepted");

    // Reset leaves index 1 standing at the first edge after release, before any hop is taken.
    a_reset_index: assert property ($fell(rst) |-> idx_reg == `HCG_IDX_FIRST)
        else $error("index not 1 after reset");

    // Two hops in a row must advance the index by two; a held request is one hop per edge.
    sequence s_two_hops;
        s_hop_mid ##1 s_hop_mid;
    endsequence

    a_index_pair: assert property (s_two_hops |=> idx_reg == $past(idx_reg, 2) + 7'h02)
        else $error("index did not advance twice on held request");

    // Without a request an index inside the table must stay put, or a stray hop would desync the link.
    sequence s_no_hop;
        clk_en && !hop_req && idx_reg <= len;
    endsequence

    a_index_hold: assert property (s_no_hop |=> $stable(idx_reg))
        else $error("index moved without a hop request");

    a_index_range: assert property (idx_reg >= `HCG_IDX_FIRST && idx_reg <= `HCG_EU_LEN)
        else $error("index outside 1 to 79");

    // Spot checks of the fixed tables at their first and last entries.
    sequence s_at_index(logic [1:0] r, logic [6:0] i);
        region == r && idx_reg == i;
    endsequence

    a_au_first: assert property (s_at_index(2'h0, 7'h01) |-> basic == 7'h02)
        else $error("Australian entry 1 is not 2");

    a_au_last: assert property (s_at_index(2'h0, 7'h3C) |-> basic == 7'h2D)
        else $error("Australian entry 60 is not 45");

    a_eu_first: assert property (s_at_index(2'h2, 7'h01) |-> basic == 7'h02)
        else $error("Europe/US entry 1 is not 2");

    a_eu_last: assert property (s_at_index(2'h2, 7'h4F) |-> basic == 7'h30)
        else $error("Europe/US entry 79 is not 48");

    a_fr_first: assert property (s_at_index(2'h3, 7'h01) |-> basic == 7'h41)
        else $error("French entry 1 is not 65");

    a_fr_last: assert property (s_at_index(2'h3, 7'h23) |-> basic == 7'h52)
        else $error("French entry 35 is not 82");

    // Sequence selectors above the regional maximum must clear the range flag.
    a_au_seq_range: assert property (clk_en && region == 2'h0 && hop_seq > `HCG_AU_SEQ_MAX |=> !ok_reg)
        else $error("Australian sequence above 20 accepted");

    a_cm_seq_range: assert property (clk_en && region == 2'h1 && hop_seq > `HCG_CM_SEQ_MAX |=> !ok_reg)
        else $error("Canada/Mexico sequence above 10 accepted");

    a_eu_seq_range: assert property (clk_en && region == 2'h2 && hop_seq > `HCG_EU_SEQ_MAX |=> !ok_reg)
        else $error("Europe/US sequence above 26 accepted");

    a_ok_accept: assert property (clk_en && region == 2'h2 && hop_set != 2'h0 && hop_seq != 5'h00
                                  && hop_seq <= `HCG_EU_SEQ_MAX |=> ok_reg)
        else $error("legal set and sequence refused");

    // A write to a legal Canada/Mexico entry lands at its edge; entry 0 is ignored.
    sequence s_cm_write;
        clk_en && cm_wr_en && cm_wr_idx >= 5'h01 && cm_wr_idx <= 5'(`HCG_CM_LEN);
    endsequence

    a_cm_store: assert property (s_cm_write |=> cm_reg[$past(cm_wr_idx) - 5'h01] == $past(cm_wr_chan))
        else $error("Canada/Mexico entry not stored");

    a_cm_ignore: assert property (clk_en && cm_wr_en && cm_wr_idx == 5'h00 |=> $stable(cm_reg[0]))
        else $error("Canada/Mexico write to entry 0 took effect");

    // Set 2 with sequence 1 adds exactly three when no wrap happens.
    a_offset_add: assert property (clk_en && hop_set == 2'h2 && hop_seq == 5'h01
                                   && {1'b0, basic} + `HCG_SET_STEP <= thr |=> chan_reg == $past(basic) + 7'h03)
        else $error("set offset is not three");

endmodule : hcg_top

// ---- hcg_hop_ctrl.sv ----
// Hop timing controller model that requests hops from the channel generator.
`timescale 1ns/1ps

module hcg_hop_ctrl (
    input  wire logic sys_clk,
    output logic      hop_req
);

    // The request is idle low until a hop burst is asked for.
    initial hop_req = 1'b0;

    // Back-to-back mode holds the request for n edges; slow mode leaves one idle cycle between pulses.
    task automatic hop(input int n, input bit slow);
        if (!slow) begin
            @(posedge sys_clk);
            hop_req <= 1'b1;
            repeat (n) @(posedge sys_clk);
            hop_req <= 1'b0;
        end else begin
            repeat (n) begin
                @(posedge sys_clk);
                hop_req <= 1'b1;
                @(posedge sys_clk);
                hop_req <= 1'b0;
            end
        end
    endtask : hop

endmodule : hcg_hop_ctrl

// ---- test_hop_channel_generator.sv ----
// Self-checking testbench of the hop channel generator.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end

module test_hop_channel_generator;

    logic        sys_clk, rst, clk_en, hop_req, cm_wr_en, cfg_ok;
    logic [1:0]  region, hop_set;
    logic [4:0]  hop_seq, cm_wr_idx;
    logic [6:0]  cm_wr_chan, hop_index, chan_num;
    logic [11:0] freq_mhz;
    int          bad_count = 0;
    int          checked   = 0;

    hcg_top u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .region(region), .hop_set(hop_set),
        .hop_seq(hop_seq), .hop_req(hop_req), .cm_wr_en(cm_wr_en), .cm_wr_idx(cm_wr_idx),
        .cm_wr_chan(cm_wr_chan), .hop_index(hop_index), .chan_num(chan_num), .freq_mhz(freq_mhz),
        .cfg_ok(cfg_ok));
    hcg_hop_ctrl u_ctl (.sys_clk(sys_clk), .hop_req(hop_req));

    // A 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Reset is held for five edges with the configuration already in place.
    task rst_to(input logic [1:0] r, input logic [1:0] s, input logic [4:0] h);
        @(posedge sys_clk);
        rst <= 1'b1; region <= r; hop_set <= s; hop_seq <= h;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : rst_to

    task cfg(input logic [1:0] r, input logic [1:0] s, input logic [4:0] h);
        @(posedge sys_clk);
        region <= r; hop_set <= s; hop_seq <= h;
    endtask : cfg

    task wr(input logic [4:0] i, input logic [6:0] c);
        @(posedge sys_clk);
        cm_wr_en <= 1'b1; cm_wr_idx <= i; cm_wr_chan <= c;
        @(posedge sys_clk);
        cm_wr_en <= 1'b0;
    endtask : wr

    // Lets one enabled edge pass so the lookup settles, then compares all outputs.
    task chk(input logic [6:0] i, input logic [6:0] c, input logic ok);
        @(posedge sys_clk);
        #1;
        `CHK("hop_index", i, hop_index)
        `CHK("chan_num", c, chan_num)
        `CHK("freq_mhz", 12'h960 + {5'h00, c}, freq_mhz)
        `CHK("cfg_ok", ok, cfg_ok)
    endtask : chk

    // Only the range flag is judged, since out-of-range arithmetic is not defined.
    task chk_range(input logic [1:0] r, input logic [1:0] s, input logic [4:0] h);
        cfg(r, s, h);
        @(posedge sys_clk);
        #1;
        `CHK("cfg_ok", 1'b0, cfg_ok)
    endtask : chk_range

    task t_au;
        rst_to(hcg_pkg::HCG_AU, 2'h1, 5'h01);
        chk(7'h01, 7'h02, 1'b1);
        u_ctl.hop(28, 1'b0);
        chk(7'h1D, 7'h3D, 1'b1);
        cfg(hcg_pkg::HCG_AU, 2'h1, 5'h02);
        chk(7'h1D, 7'h02, 1'b1);
        cfg(hcg_pkg::HCG_AU, 2'h3, 5'h14);
        chk(7'h1D, 7'h1A, 1'b1);
        u_ctl.hop(31, 1'b1);
        chk(7'h3C, 7'h0A, 1'b1);
        u_ctl.hop(1, 1'b0);
        chk(7'h01, 7'h1B, 1'b1);
        u_ctl.hop(1, 1'b0);
        chk(7'h02, 7'h12, 1'b1);
        chk_range(hcg_pkg::HCG_AU, 2'h3, 5'h15);
        chk_range(hcg_pkg::HCG_AU, 2'h0, 5'h01);
    endtask : t_au

    task t_cm;
        rst_to(hcg_pkg::HCG_CM, 2'h1, 5'h01);
        chk(7'h01, 7'h34, 1'b1);
        u_ctl.hop(1, 1'b0);
        chk(7'h02, 7'h3A, 1'b1);
        wr(5'h03, 7'h48);
        u_ctl.hop(1, 1'b0);
        chk(7'h03, 7'h48, 1'b1);
        cfg(hcg_pkg::HCG_CM, 2'h3, 5'h0A);
        chk(7'h03, 7'h39, 1'b1);
        wr(5'h03, 7'h42);
        chk(7'h03, 7'h51, 1'b1);
        u_ctl.hop(27, 1'b0);
        chk(7'h1E, 7'h43, 1'b1);
        u_ctl.hop(1, 1'b1);
        chk(7'h01, 7'h43, 1'b1);
        wr(5'h00, 7'h10);
        chk(7'h01, 7'h43, 1'b1);
        chk_range(hcg_pkg::HCG_CM, 2'h3, 5'h0B);
    endtask : t_cm

    task t_eu;
        rst_to(hcg_pkg::HCG_EU, 2'h1, 5'h01);
        chk(7'h01, 7'h02, 1'b1);
        u_ctl.hop(2, 1'b0);
        chk(7'h03, 7'h40, 1'b1);
        cfg(hcg_pkg::HCG_EU, 2'h3, 5'h1A);
        chk(7'h03, 7'h10, 1'b1);
        u_ctl.hop(76, 1'b0);
        chk(7'h4F, 7'h4F, 1'b1);
        u_ctl.hop(1, 1'b0);
        chk(7'h01, 7'h21, 1'b1);
        u_ctl.hop(7, 1'b1);
        chk(7'h08, 7'h50, 1'b1);
        chk_range(hcg_pkg::HCG_EU, 2'h1, 5'h1B);
    endtask : t_eu

    task t_fr;
        rst_to(hcg_pkg::HCG_FR, 2'h1, 5'h01);
        chk(7'h01, 7'h41, 1'b1);
        u_ctl.hop(2, 1'b0);
        chk(7'h03, 7'h42, 1'b1);
        cfg(hcg_pkg::HCG_FR, 2'h3, 5'h0B);
        chk(7'h03, 7'h52, 1'b1);
        u_ctl.hop(1, 1'b0);
        chk(7'h04, 7'h3D, 1'b1);
        u_ctl.hop(31, 1'b1);
        chk(7'h23, 7'h3F, 1'b1);
        u_ctl.hop(1, 1'b0);
        chk(7'h01, 7'h51, 1'b1);
        // Hops while the clock enable is low must leave the index where it was.
        @(posedge sys_clk);
        clk_en <= 1'b0;
        u_ctl.hop(2, 1'b0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        chk(7'h01, 7'h51, 1'b1);
        chk_range(hcg_pkg::HCG_FR, 2'h3, 5'h0C);
    endtask : t_fr

    task results;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // The whole run needs under two thousand cycles; a hang is cut well beyond that.
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        results();
    end

    initial begin
        rst = 1'b1; clk_en = 1'b1; region = hcg_pkg::HCG_AU; hop_set = 2'h1; hop_seq = 5'h01;
        cm_wr_en = 1'b0; cm_wr_idx = 5'h00; cm_wr_chan = 7'h00;
        t_au();
        t_cm();
        t_eu();
        t_fr();
        results();
    end

endmodule : test_hop_channel_generator
